// ---- src/lisu_pkg.sv ----
package lisu_pkg;
   // register placement on the local register port
   localparam int           ADDR_W         = 8;
   localparam logic [7:0]   ICS_OFS        = 8'h68;
   localparam int           DATA_W         = 32;
   // lower-half bits, and bit 16, that this block keeps because its sources need them
   localparam int           BIT_MBOX_EN    = 3;
   localparam int           BIT_RETRY_EN   = 12;
   localparam int           BIT_LOUT_EN    = 16;
   // upper-half field positions
   localparam int           BIT_DMA0_EN    = 18;
   localparam int           BIT_DMA1_EN    = 19;
   localparam int           BIT_DBELL_ACT  = 20;
   localparam int           BIT_DMA0_ACT   = 21;
   localparam int           BIT_DMA1_ACT   = 22;
   localparam int           BIT_STEST_ACT  = 23;
   localparam int           BIT_ABORT_LO   = 24;
   localparam int           BIT_MBOX_LO    = 28;
   localparam int           N_ABORT        = 4;
   localparam int           N_MBOX         = 4;
   // abort indicator order: direct master, channel 0, channel 1, retry limit
   localparam int           ABT_DIRECT     = 0;
   localparam int           ABT_CH0        = 1;
   localparam int           ABT_CH1        = 2;
   localparam int           ABT_RETRY      = 3;
   // reset values
   localparam logic         RST_LOUT_EN    = 1'b1;
   localparam logic [3:0]   RST_ABORT_B    = 4'hF;
   localparam logic [3:0]   RST_MBOX       = 4'h0;
   localparam logic [31:0]  RST_RDATA      = 32'h00000000;
   // consecutive master retries before a target abort is forced
   localparam int           RETRY_LIMIT    = 256;
   localparam int           RETRY_CNT_W    = 9;
   localparam logic [8:0]   RETRY_LAST     = 9'(RETRY_LIMIT - 1);
   localparam logic [8:0]   RETRY_ZERO     = 9'h000;
   localparam logic [8:0]   RETRY_ONE      = 9'h001;
endpackage

// ---- src/lisu_retry_limit.sv ----
// counts consecutive master retries to one target
module lisu_retry_limit
   import lisu_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic retry_en,
   input  wire logic retry_seen,
   input  wire logic xfer_end,
   output logic      retry_abort
);
   typedef struct packed {
      logic [RETRY_CNT_W-1:0] cnt;
      logic                   abort;
   } lisu_rl_state_t;

   lisu_rl_state_t state;
   lisu_rl_state_t next_state;

   // count saturates when the limit is off so retries simply go on forever
   always_comb begin
      next_state       = state;
      next_state.abort = 1'b0;
      if (retry_seen) begin
         if (retry_en && state.cnt == RETRY_LAST) begin
            next_state.abort = 1'b1;
            next_state.cnt   = RETRY_ZERO;
         end else if (state.cnt != RETRY_LAST) begin
            next_state.cnt = state.cnt + RETRY_ONE;
         end
      end else if (xfer_end) begin
         next_state.cnt = RETRY_ZERO; // a non-retry end breaks the run
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign retry_abort = state.abort;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_retry_off_none: assert property (!retry_en |=> !retry_abort)
      else $error("retry abort raised while limit disabled");
endmodule

// ---- src/lisu_top.sv ----
module lisu_top
   import lisu_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [lisu_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [lisu_pkg::DATA_W-1:0] reg_wdata,
   output logic      [lisu_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                    dbell_pend,
   input  wire logic                    dma0_stat,
   input  wire logic                    dma1_stat,
   input  wire logic                    self_test_start,
   input  wire logic                    abort_seen,
   input  wire logic [2:0]              abort_master,
   input  wire logic                    abort_clr,
   input  wire logic                    retry_seen,
   input  wire logic                    xfer_end,
   input  wire logic [3:0]              mbox_host_wr,
   input  wire logic [3:0]              mbox_local_rd,
   output logic                         retry_abort,
   output logic                         local_int
);
   import lisu_pkg::*;

   typedef struct packed {
      logic                 mbox_en;
      logic                 retry_en;
      logic                 lout_en;
      logic                 dma0_en;
      logic                 dma1_en;
      logic                 dbell_act;
      logic                 dma0_act;
      logic                 dma1_act;
      logic                 stest_act;
      logic [N_ABORT-1:0]   abort_b;
      logic [N_MBOX-1:0]    mbox;
      logic [DATA_W-1:0]    rdata;
      logic                 irq;
   } lisu_state_t;

   lisu_state_t state;
   lisu_state_t next_state;
   logic        rl_abort;
   logic [N_ABORT-1:0] abort_set;

   // one decoder shared by the read and write paths
   function automatic logic ics_hit(input logic [ADDR_W-1:0] addr);
      return addr == ICS_OFS;
   endfunction

   // assemble the register image; unkept low bits read as zero
   function automatic logic [DATA_W-1:0] ics_image(input lisu_state_t s);
      logic [DATA_W-1:0] v;
      v                                    = '0;
      v[BIT_MBOX_EN]                       = s.mbox_en;
      v[BIT_RETRY_EN]                      = s.retry_en;
      v[BIT_LOUT_EN]                       = s.lout_en;
      v[BIT_DMA0_EN]                       = s.dma0_en;
      v[BIT_DMA1_EN]                       = s.dma1_en;
      v[BIT_DBELL_ACT]                     = s.dbell_act;
      v[BIT_DMA0_ACT]                      = s.dma0_act;
      v[BIT_DMA1_ACT]                      = s.dma1_act;
      v[BIT_STEST_ACT]                     = s.stest_act;
      v[BIT_ABORT_LO +: N_ABORT]           = s.abort_b;
      v[BIT_MBOX_LO +: N_MBOX]             = s.mbox;
      return v;
   endfunction

   lisu_retry_limit u_retry (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .retry_en    (state.retry_en),
      .retry_seen  (retry_seen),
      .xfer_end    (xfer_end),
      .retry_abort (rl_abort)
   );

   // which abort indicators fall this cycle
   always_comb begin
      abort_set             = '0;
      abort_set[ABT_DIRECT] = abort_seen & abort_master[ABT_DIRECT];
      abort_set[ABT_CH0]    = abort_seen & abort_master[ABT_CH0];
      abort_set[ABT_CH1]    = abort_seen & abort_master[ABT_CH1];
      abort_set[ABT_RETRY]  = rl_abort;
   end

   always_comb begin
      next_state = state;
      // control bits; status bits ignore writes
      if (reg_wr && ics_hit(reg_addr)) begin
         next_state.mbox_en  = reg_wdata[BIT_MBOX_EN];
         next_state.retry_en = reg_wdata[BIT_RETRY_EN];
         next_state.lout_en  = reg_wdata[BIT_LOUT_EN];
         next_state.dma0_en  = reg_wdata[BIT_DMA0_EN];
         next_state.dma1_en  = reg_wdata[BIT_DMA1_EN];
      end
      // active flags follow their sources, so clearing a source clears the flag
      next_state.dbell_act = dbell_pend;
      next_state.dma0_act  = dma0_stat & state.dma0_en;
      next_state.dma1_act  = dma1_stat & state.dma1_en;
      next_state.stest_act = self_test_start;
      // indicators fall on an abort; a clear in the same cycle loses to a fresh abort
      for (int i = 0; i < N_ABORT; i++) begin
         if (abort_set[i]) begin
            next_state.abort_b[i] = 1'b0;
         end else if (abort_clr) begin
            next_state.abort_b[i] = 1'b1;
         end
      end
      // mailbox flags: set wins over the local read that clears them
      for (int i = 0; i < N_MBOX; i++) begin
         if (mbox_host_wr[i] && state.mbox_en) begin
            next_state.mbox[i] = 1'b1;
         end else if (mbox_local_rd[i]) begin
            next_state.mbox[i] = 1'b0;
         end
      end
      // read data is captured so it stays stable until the next read
      if (reg_rd) begin
         next_state.rdata = ics_hit(reg_addr) ? ics_image(state) : RST_RDATA;
      end
      next_state.irq = next_state.lout_en & (next_state.dbell_act | next_state.dma0_act
                       | next_state.dma1_act | (|next_state.mbox));
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state         <= '0;
         state.lout_en <= RST_LOUT_EN;
         state.abort_b <= RST_ABORT_B;
         state.mbox    <= RST_MBOX;
         state.rdata   <= RST_RDATA;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata   = state.rdata;
   assign retry_abort = rl_abort;
   assign local_int   = state.irq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_mbox_write(int i);
      mbox_host_wr[i] && state.mbox_en;
   endsequence
   sequence s_abort_ch0;
      abort_seen && abort_master[ABT_CH0];
   endsequence

   a_dma0_flag: assert property (dma0_stat && state.dma0_en |=> state.dma0_act)
      else $error("channel 0 active flag did not follow status");
   a_dma1_clear: assert property (!dma1_stat |=> !state.dma1_act)
      else $error("channel 1 flag held after status cleared");
   a_dbell_follow: assert property (state.dbell_act == $past(dbell_pend))
      else $error("doorbell flag mismatch");
   a_dma_disabled: assert property (!state.dma0_en && !state.dma1_en |=> !state.dma0_act && !state.dma1_act)
      else $error("channel flag set while disabled");
   a_stest_follow: assert property ($rose(self_test_start) |=> state.stest_act)
      else $error("self-test flag missed");
   // low one cycle after the abort, and still low a cycle later unless a clear came in between
   a_abort_ch0: assert property (s_abort_ch0 |=> !state.abort_b[ABT_CH0] ##1 (!state.abort_b[ABT_CH0] || $past(abort_clr)))
      else $error("channel 0 abort indicator not low");
   a_retry_ind: assert property (rl_abort |=> !state.abort_b[ABT_RETRY])
      else $error("retry abort indicator not low");
   a_mailbox_word_zero_set: assert property (s_mbox_write(0) |=> state.mbox[0])
      else $error("mailbox zero flag not set");
   // a host write while the enable is low must leave the flag clear
   a_mbox_gated: assert property (!state.mbox_en && !state.mbox[1] |=> !state.mbox[1])
      else $error("mailbox flag set while disabled");
   a_mbox_read: assert property (mbox_local_rd[2] && !(mbox_host_wr[2] && state.mbox_en) |=> !state.mbox[2])
      else $error("mailbox flag survived local read");
   a_lout_gate: assert property (!state.lout_en |-> !local_int)
      else $error("local interrupt driven while output disabled");
   a_irq_source: assert property (local_int |-> state.dbell_act || state.dma0_act || state.dma1_act
                                  || (|state.mbox))
      else $error("local interrupt without an active source");
endmodule

// ---- verif/lisu_far_side.sv ----
// bus master side: a run of back-to-back retries, then a clean transfer end
module lisu_far_side
   import lisu_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       start,
   input  wire logic [9:0] burst,
   output logic            retry_seen,
   output logic            xfer_end
);
   timeunit 1ns;
   timeprecision 1ps;
   int left = 0;
   initial {retry_seen, xfer_end} = 2'b00;
   // run length is latched on the rising edge so the request never races it
   always @(posedge clk_sys) begin
      if (start) left <= int'(burst) + 1;
      else if (left > 0) left <= left - 1;
   end
   // outputs move on the falling edge, clear of the block's sampling edge
   always @(negedge clk_sys) begin
      retry_seen <= (left > 1);
      xfer_end   <= (left == 1);
   end
endmodule

// ---- verif/test_local_interrupt_status_upper.sv ----
module test_local_interrupt_status_upper;
   timeunit 1ns;
   timeprecision 1ps;
   import lisu_pkg::*;
   logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [3:0]  src = 4'h0, mbox_host_wr = 4'h0, mbox_local_rd = 4'h0;
   logic [2:0]  abort_master = 3'h0;
   logic        abort_clr = 1'b0, start = 1'b0, retry_seen, xfer_end, retry_abort, local_int;
   logic [9:0]  burst = 10'h000;
   int          fails = 0, samples_checked = 0, hits = 0;
   lisu_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dbell_pend(src[0]), .dma0_stat(src[1]), .dma1_stat(src[2]),
      .self_test_start(src[3]), .abort_seen(|abort_master), .abort_master(abort_master), .abort_clr(abort_clr),
      .retry_seen(retry_seen), .xfer_end(xfer_end), .mbox_host_wr(mbox_host_wr), .mbox_local_rd(mbox_local_rd),
      .retry_abort(retry_abort), .local_int(local_int));
   lisu_far_side far (.clk_sys(clk_sys), .start(start), .burst(burst), .retry_seen(retry_seen),
      .xfer_end(xfer_end));
   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;
   // every abort pulse is counted, so a double pulse shows up too
   always @(posedge clk_sys) if (retry_abort === 1'b1) hits++;
   task automatic chk(input logic [31:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk_sys) reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
      @(negedge clk_sys) reg_rd = 1'b0;
      @(negedge clk_sys) chk(reg_rdata, exp, "register read");
   endtask
   task automatic pulse(input logic [3:0] mw, mr, input logic [2:0] am, input logic clr);
      @(negedge clk_sys) {mbox_host_wr, mbox_local_rd, abort_master, abort_clr} = {mw, mr, am, clr};
      @(negedge clk_sys) {mbox_host_wr, mbox_local_rd, abort_master, abort_clr} = 12'h000;
      repeat (2) @(negedge clk_sys);
   endtask
   // one source alone under the given enables; flag and output must match exp and ei, then both must clear when the source drops
   task automatic one_src(input int k, input logic [31:0] en, exp, input logic ei);
      wr(8'h68, en);
      @(negedge clk_sys) src[k] = 1'b1;
      rd(8'h68, exp);
      chk({31'h0, local_int}, {31'h0, ei}, "interrupt raised");
      @(negedge clk_sys) src[k] = 1'b0;
      rd(8'h68, exp & 32'hFF0FFFFF);
      chk({31'h0, local_int}, 32'h0, "interrupt removed");
   endtask
   task automatic retries(input logic [9:0] n);
      @(negedge clk_sys) {start, burst} = {1'b1, n};
      @(negedge clk_sys) start = 1'b0;
      repeat (int'(n) + 4) @(negedge clk_sys);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      rd(8'h68, 32'h0F010000);
      wr(8'h68, 32'hFFFFFFFF);
      rd(8'h68, 32'h0F0D1008);
      wr(8'h6C, 32'hFFFFFFFF);
      rd(8'h6C, 32'h0);
      one_src(0, 32'h000D1008, 32'h0F1D1008, 1'b1);
      one_src(1, 32'h000D1008, 32'h0F2D1008, 1'b1);
      one_src(2, 32'h000D1008, 32'h0F4D1008, 1'b1);
      one_src(3, 32'h000D1008, 32'h0F8D1008, 1'b0);
      one_src(1, 32'h00011008, 32'h0F011008, 1'b0);
      one_src(2, 32'h00011008, 32'h0F011008, 1'b0);
      one_src(0, 32'h00001008, 32'h0F101008, 1'b0);
      wr(8'h68, 32'h000D1008);
      for (int i = 0; i < 3; i++) begin
         pulse(4'h0, 4'h0, 3'(1 << i), 1'b0);
         rd(8'h68, 32'h0F0D1008 & ~(32'h01000000 << i));
         pulse(4'h0, 4'h0, 3'h0, 1'b1);
         rd(8'h68, 32'h0F0D1008);
      end
      for (int i = 0; i < 4; i++) begin
         pulse(4'(1 << i), 4'h0, 3'h0, 1'b0);
         rd(8'h68, 32'h0F0D1008 | (32'h10000000 << i));
         chk({31'h0, local_int}, 32'h1, "mailbox interrupt");
         pulse(4'h0, 4'(1 << i), 3'h0, 1'b0);
         rd(8'h68, 32'h0F0D1008);
      end
      wr(8'h68, 32'h000D1000);
      pulse(4'hF, 4'h0, 3'h0, 1'b0);
      rd(8'h68, 32'h0F0D1000);
      retries(10'h100);
      chk(hits, 1, "retry abort count");
      rd(8'h68, 32'h070D1000);
      pulse(4'h0, 4'h0, 3'h0, 1'b1);
      retries(10'h0FF);
      rd(8'h68, 32'h0F0D1000);
      wr(8'h68, 32'h000D0000);
      retries(10'h12C);
      chk(hits, 1, "retries without limit");
      summarize();
   end
   // watchdog far beyond the roughly one thousand cycles the sequence needs
   initial begin
      #50000;
      fails++;
      summarize();
   end
endmodule
